// ### logic/pipc_pkg.sv
// Shared message codes, link states and widths for package idle coordination.
`default_nettype none
package pipc_pkg;
    localparam int PIPC_LTR_W = 10;
    localparam int PIPC_VDM_W = 8;
    // Vendor-defined message opcodes carried on the link.
    localparam logic [7:0] PIPC_OP_NONE = 8'h00;
    localparam logic [7:0] PIPC_OP_REQ = 8'h01;
    localparam logic [7:0] PIPC_OP_RSP = 8'h02;
    localparam logic [7:0] PIPC_OP_GO = 8'h03;
    localparam logic [7:0] PIPC_OP_RSTPREP = 8'h04;
    localparam logic [7:0] PIPC_OP_MGMT = 8'h05;
    // Vendor-defined message header byte; value arbitrary.
    localparam logic [7:0] PIPC_VDM_TAG = 8'h7E;
    localparam logic [9:0] PIPC_LTR_ZERO = 10'h000;
    // Link power states; L0s deliberately has no code.
    typedef enum logic [1:0] {PIPC_L0 = 2'h0, PIPC_L1 = 2'h1, PIPC_L2 = 2'h2} pipc_link_e;
endpackage : pipc_pkg
`default_nettype wire

// ### logic/pipc_if.sv
// Link carrying power messages and link state between device and controller.
`timescale 1ns/1ps
`default_nettype none
interface pipc_if
    import pipc_pkg::*;
();
    logic d2c_valid;
    logic [7:0] d2c_tag;
    logic [7:0] d2c_op;
    logic [9:0] d2c_ltr;
    logic c2d_valid;
    logic [7:0] c2d_tag;
    logic [7:0] c2d_op;
    logic [9:0] c2d_ltr;
    logic l1_enter_req;
    logic wake_req;
    logic exit_req;
    pipc_link_e link_state;
    modport device (output d2c_valid, d2c_tag, d2c_op, d2c_ltr, l1_enter_req, wake_req,
                    input c2d_valid, c2d_tag, c2d_op, c2d_ltr, exit_req, link_state);
    modport ctrl (input d2c_valid, d2c_tag, d2c_op, d2c_ltr, l1_enter_req, wake_req,
                  output c2d_valid, c2d_tag, c2d_op, c2d_ltr, exit_req, link_state);
endinterface : pipc_if
`default_nettype wire

// ### logic/pipc_vdm_decode.sv
// Decoder that accepts only well-tagged vendor-defined power messages.
`timescale 1ns/1ps
`default_nettype none
module pipc_vdm_decode
    import pipc_pkg::*;
(
    input wire logic valid,
    input wire logic [7:0] tag,
    input wire logic [7:0] op,
    output logic is_req,
    output logic is_rsp,
    output logic is_go,
    output logic is_rstprep,
    output logic is_mgmt
);
    logic ok;
    // Messages without the vendor tag are dropped rather than guessed at.
    assign ok = valid && (tag == PIPC_VDM_TAG);
    assign is_req = ok && (op == PIPC_OP_REQ);
    assign is_rsp = ok && (op == PIPC_OP_RSP);
    assign is_go = ok && (op == PIPC_OP_GO);
    assign is_rstprep = ok && (op == PIPC_OP_RSTPREP);
    assign is_mgmt = ok && (op == PIPC_OP_MGMT);
endmodule : pipc_vdm_decode
`default_nettype wire

// ### logic/pipc_device.sv
// Device end: idle state machine, message sender and link L1 control.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Idle wish sends request with own tolerance.
// - Allowed request answered by matching response.
// - Local idle only while shared resources accessible.
// - No low power while peer needs memory.
// - Master sends go with latency after coordination.
// - Coherent device uses prepare/request/response/go.
// - Power messages encoded as vendor-defined messages.
// - Processor idles then moves link to L1.
// - Device initiates link L1 on deep idle.
// - Device exit uses in-band wake to L0.
// - Processor restores resources, then responds.
// - Processor exits L1, then sends zero go.
// - Zero-latency go blocks further low power.
// - Link uses L1/L2, never L0s; the controller only ever moves the link between L0 and L1, never to L2.
// - Arbiter layer commands physical power states; there is no arbiter layer, the controller sets link_state itself.
// - Management messages forwarded both directions; the controller drops those it receives from the device.
// - No protocol packets until link leaves L1.
module pipc_device
    import pipc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    pipc_if.device lnk,
    input wire logic idle_wish,
    input wire logic wake_wish,
    input wire logic [9:0] own_ltr,
    input wire logic peer_needs_mem,
    input wire logic mgmt_tx_valid,
    output logic mgmt_rx_pulse,
    output logic [9:0] granted_ltr,
    output logic local_idle_ok,
    output logic proto_tx_ok,
    output logic [1:0] dev_state
);
    typedef enum logic [1:0] {PIPC_ACTIVE, PIPC_IDLE_REQ, PIPC_IDLE_GNT, PIPC_DEEP} pipc_dstate_e;
    typedef struct packed {
        pipc_dstate_e st;
        logic tx_valid;
        logic [7:0] tx_op;
        logic [9:0] tx_ltr;
        logic l1_req;
        logic wake;
        logic pinned;
        logic mgmt_rx;
        logic [9:0] gnt;
        logic idle_ok;
        logic tx_ok;
    } pipc_dev_s;
    pipc_dev_s s_q, s_d;
    logic rx_req, rx_rsp, rx_go, rx_rst, rx_mgmt;
    ////////////////////////////////////////////////////////////////
    // Incoming message classification.
    pipc_vdm_decode u_dec (
        .valid(lnk.c2d_valid),
        .tag(lnk.c2d_tag),
        .op(lnk.c2d_op),
        .is_req(rx_req),
        .is_rsp(rx_rsp),
        .is_go(rx_go),
        .is_rstprep(rx_rst),
        .is_mgmt(rx_mgmt)
    );
    ////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb
    begin
        s_d = s_q;
        s_d.tx_valid = 1'b0;
        s_d.tx_op = PIPC_OP_NONE;
        s_d.tx_ltr = PIPC_LTR_ZERO;
        s_d.wake = 1'b0;
        s_d.mgmt_rx = rx_mgmt;
        if (rx_go && lnk.c2d_ltr == PIPC_LTR_ZERO)
        begin
            s_d.pinned = 1'b1;
        end
        else if (rx_go)
        begin
            s_d.pinned = 1'b0;
        end
        unique case (s_q.st)
            PIPC_ACTIVE:
            begin
                // hold off while peer needs memory
                if (idle_wish && !peer_needs_mem && !s_d.pinned)
                begin
                    s_d.tx_valid = 1'b1;
                    s_d.tx_op = PIPC_OP_REQ;
                    s_d.tx_ltr = own_ltr;
                    s_d.st = PIPC_IDLE_REQ;
                end
            end
            PIPC_IDLE_REQ:
            begin
                if (rx_rsp)
                begin
                    s_d.gnt = lnk.c2d_ltr;
                    s_d.st = PIPC_IDLE_GNT;
                end
                else if (rx_rst || !idle_wish)
                begin
                    s_d.st = PIPC_ACTIVE;
                end
            end
            PIPC_IDLE_GNT:
            begin
                // device starts L1 on deep idle
                if (rx_go && lnk.c2d_ltr != PIPC_LTR_ZERO && !peer_needs_mem)
                begin
                    s_d.gnt = lnk.c2d_ltr;
                    s_d.l1_req = 1'b1;
                    s_d.st = PIPC_DEEP;
                end
                else if (rx_go || !idle_wish || rx_rst)
                begin
                    s_d.st = PIPC_ACTIVE;
                end
            end
            PIPC_DEEP:
            begin
                if (wake_wish || peer_needs_mem)
                begin
                    s_d.l1_req = 1'b0;
                    s_d.wake = lnk.link_state != PIPC_L0;
                end
                if (rx_go && lnk.c2d_ltr == PIPC_LTR_ZERO)
                begin
                    s_d.l1_req = 1'b0;
                    s_d.st = PIPC_ACTIVE;
                end
                else if (rx_rsp && !s_q.l1_req)
                begin
                    s_d.st = PIPC_ACTIVE;
                end
                else if (lnk.exit_req)
                begin
                    s_d.l1_req = 1'b0;
                end
            end
        endcase
        if (rx_req && !s_d.tx_valid)
        begin
            s_d.tx_valid = 1'b1;
            s_d.tx_op = PIPC_OP_RSP;
            s_d.tx_ltr = (lnk.c2d_ltr < own_ltr) ? lnk.c2d_ltr : own_ltr;
        end
        else if (mgmt_tx_valid && !s_d.tx_valid)
        begin
            s_d.tx_valid = 1'b1;
            s_d.tx_op = PIPC_OP_MGMT;
        end
        // local idle only while resources shared
        s_d.idle_ok = (s_d.st == PIPC_IDLE_GNT || s_d.st == PIPC_DEEP)
                      && !peer_needs_mem && !s_d.pinned;
        // only L0 permits traffic
        // Traffic stops once L1 is asked for, because the link may switch at the next edge.
        s_d.tx_ok = (lnk.link_state == PIPC_L0) && !s_d.l1_req;
    end
    ////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // messages leave with vendor tag
    assign lnk.d2c_valid = s_q.tx_valid;
    assign lnk.d2c_tag = PIPC_VDM_TAG;
    assign lnk.d2c_op = s_q.tx_op;
    assign lnk.d2c_ltr = s_q.tx_ltr;
    assign lnk.l1_enter_req = s_q.l1_req;
    assign lnk.wake_req = s_q.wake;
    assign mgmt_rx_pulse = s_q.mgmt_rx;
    assign granted_ltr = s_q.gnt;
    assign local_idle_ok = s_q.idle_ok;
    assign proto_tx_ok = s_q.tx_ok;
    assign dev_state = s_q.st;
endmodule : pipc_device
`default_nettype wire

// ### logic/pipc_ctrl.sv
// Controller end: answers requests, sends go, owns link power state.
`timescale 1ns/1ps
`default_nettype none
module pipc_ctrl
    import pipc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    pipc_if.ctrl lnk,
    input wire logic cpu_halted,
    input wire logic need_low_lat,
    input wire logic [9:0] host_ltr,
    input wire logic send_rstprep,
    input wire logic send_mgmt,
    input wire logic send_idle_req,
    output logic [1:0] link_now,
    output logic req_seen
);
    typedef struct packed {
        logic tx_valid;
        logic [7:0] tx_op;
        logic [9:0] tx_ltr;
        logic [9:0] agreed;
        logic go_due;
        logic rsp_due;
        logic exit;
        logic zero_due;
        pipc_link_e link;
        logic seen;
        logic low_lat;
    } pipc_ctl_s;
    pipc_ctl_s s_q, s_d;
    logic rx_req, rx_rsp;
    pipc_vdm_decode u_dec (
        .valid(lnk.d2c_valid),
        .tag(lnk.d2c_tag),
        .op(lnk.d2c_op),
        .is_req(rx_req),
        .is_rsp(rx_rsp),
        .is_go(),
        .is_rstprep(),
        .is_mgmt()
    );
    ////////////////////////////////////////////////////////////////
    // Next state: one outgoing message per cycle, reset-prepare first.
    always_comb
    begin
        s_d = s_q;
        s_d.tx_valid = 1'b0;
        s_d.tx_op = PIPC_OP_NONE;
        s_d.tx_ltr = PIPC_LTR_ZERO;
        s_d.seen = rx_req;
        s_d.low_lat = need_low_lat;
        if (need_low_lat && s_q.link != PIPC_L0)
        begin
            s_d.exit = 1'b1;
        end
        // halted processor moves link L1
        // A pending zero go keeps the link out of L1 until it has been sent.
        if (s_q.link == PIPC_L0 && lnk.l1_enter_req && cpu_halted && !need_low_lat && !s_q.zero_due)
        begin
            s_d.link = PIPC_L1;
        end
        else if (s_q.link == PIPC_L1 && (lnk.wake_req || s_q.exit))
        begin
            s_d.link = PIPC_L0;
            s_d.exit = 1'b0;
        end
        if (send_rstprep)
        begin
            s_d.tx_valid = 1'b1;
            s_d.tx_op = PIPC_OP_RSTPREP;
        end
        else if (send_mgmt)
        begin
            s_d.tx_valid = 1'b1;
            s_d.tx_op = PIPC_OP_MGMT;
        end
        else if (send_idle_req)
        begin
            s_d.tx_valid = 1'b1;
            s_d.tx_op = PIPC_OP_REQ;
            s_d.tx_ltr = host_ltr;
        end
        else if (s_q.link == PIPC_L0 && s_q.zero_due)
        begin
            s_d.tx_valid = 1'b1;
            s_d.tx_op = PIPC_OP_GO;
            s_d.zero_due = 1'b0;
            s_d.go_due = 1'b0;
        end
        else if (s_q.rsp_due)
        begin
            s_d.tx_valid = 1'b1;
            s_d.tx_op = PIPC_OP_RSP;
            s_d.tx_ltr = s_q.agreed;
            s_d.rsp_due = 1'b0;
        end
        else if (s_q.go_due && cpu_halted)
        begin
            s_d.tx_valid = 1'b1;
            s_d.tx_op = PIPC_OP_GO;
            s_d.tx_ltr = s_q.agreed;
            s_d.go_due = 1'b0;
        end
        // Pending flags are set after the send chain, so an event in the clearing cycle wins.
        // wake restores, then responds
        if (lnk.wake_req && s_q.link == PIPC_L1)
        begin
            s_d.rsp_due = 1'b1;
        end
        // Only a fresh low-latency demand queues a zero go; a held level sends only one.
        if (need_low_lat && !s_q.low_lat)
        begin
            s_d.zero_due = 1'b1;
        end
        if (rx_req)
        begin
            s_d.agreed = (lnk.d2c_ltr < host_ltr) ? lnk.d2c_ltr : host_ltr;
            s_d.rsp_due = 1'b1;
            s_d.go_due = 1'b1;
        end
        if (rx_rsp)
        begin
            s_d.agreed = lnk.d2c_ltr;
        end
    end
    ////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // messages leave with vendor tag
    assign lnk.c2d_valid = s_q.tx_valid;
    assign lnk.c2d_tag = PIPC_VDM_TAG;
    assign lnk.c2d_op = s_q.tx_op;
    assign lnk.c2d_ltr = s_q.tx_ltr;
    assign lnk.exit_req = s_q.exit;
    assign lnk.link_state = s_q.link;
    assign link_now = s_q.link;
    assign req_seen = s_q.seen;
endmodule : pipc_ctrl
`default_nettype wire

// ### tb/pipc_sva.sv
// Assertions on the power-message link between the two ends.
`timescale 1ns/1ps
`default_nettype none
module pipc_sva
    import pipc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic d2c_valid,
    input wire logic [7:0] d2c_tag,
    input wire logic [7:0] d2c_op,
    input wire logic [9:0] d2c_ltr,
    input wire logic c2d_valid,
    input wire logic [7:0] c2d_tag,
    input wire logic [7:0] c2d_op,
    input wire logic [9:0] c2d_ltr,
    input wire logic l1_enter_req,
    input wire logic wake_req,
    input wire logic exit_req,
    input wire pipc_link_e link_state
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    // Message kinds seen on each direction.
    sequence s_dreq;
        d2c_valid && d2c_op == PIPC_OP_REQ;
    endsequence
    sequence s_crsp;
        c2d_valid && c2d_op == PIPC_OP_RSP;
    endsequence
    sequence s_go0;
        c2d_valid && c2d_op == PIPC_OP_GO && c2d_ltr == PIPC_LTR_ZERO;
    endsequence
    a_dev_tagged: assert property (d2c_valid |-> d2c_tag == PIPC_VDM_TAG)
        else $error("device message tag wrong");
    a_ctl_tagged: assert property (c2d_valid |-> c2d_tag == PIPC_VDM_TAG)
        else $error("controller message tag wrong");
    a_no_l0s: assert property (link_state inside {PIPC_L0, PIPC_L1, PIPC_L2})
        else $error("illegal link state");
    a_req_answered: assert property (s_dreq |-> ##[1:8] s_crsp)
        else $error("request not answered");
    a_l1_by_dev: assert property (link_state == PIPC_L1 && $past(link_state) != PIPC_L1
        |-> $past(l1_enter_req)) else $error("L1 without device request");
    a_wake_to_l0: assert property (wake_req |-> ##[1:8] link_state == PIPC_L0)
        else $error("wake did not reach L0");
    a_exit_held: assert property (exit_req && link_state != PIPC_L0 |=> exit_req != (link_state == PIPC_L0))
        else $error("exit request dropped early");
    a_exit_bound: assert property ($rose(exit_req) |-> ##[1:8] link_state == PIPC_L0)
        else $error("exit did not reach L0");
    a_go0_on_l0: assert property (s_go0 |-> link_state == PIPC_L0)
        else $error("zero go before link runs");
    a_go0_no_l1: assert property (s_go0 |=> !l1_enter_req [*2])
        else $error("L1 request after zero go");
endmodule : pipc_sva
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the device and controller joined over the link.
`timescale 1ns/1ps
`default_nettype none
module tb
    import pipc_pkg::*;
;
    logic core_clk, reset_n, idle_wish, wake_wish, peer_needs_mem, mgmt_tx_valid;
    logic cpu_halted, need_low_lat, send_rstprep, mgmt_rx_pulse, local_idle_ok, proto_tx_ok, req_seen;
    logic send_mgmt, send_idle_req;
    logic [9:0] own_ltr, host_ltr, granted_ltr;
    logic [1:0] dev_state, link_now;
    int n_mismatch = 0;
    int checked = 0;
    pipc_if lnk ();
    pipc_device u_pipc_device (.core_clk, .reset_n, .lnk(lnk), .idle_wish, .wake_wish, .own_ltr,
        .peer_needs_mem, .mgmt_tx_valid, .mgmt_rx_pulse, .granted_ltr, .local_idle_ok, .proto_tx_ok, .dev_state);
    pipc_ctrl u_pipc_ctrl (.core_clk, .reset_n, .lnk(lnk), .cpu_halted, .need_low_lat, .host_ltr,
        .send_rstprep, .send_mgmt, .send_idle_req, .link_now, .req_seen);
    pipc_sva u_sva (.core_clk, .reset_n, .d2c_valid(lnk.d2c_valid), .d2c_tag(lnk.d2c_tag),
        .d2c_op(lnk.d2c_op), .d2c_ltr(lnk.d2c_ltr), .c2d_valid(lnk.c2d_valid), .c2d_tag(lnk.c2d_tag),
        .c2d_op(lnk.c2d_op), .c2d_ltr(lnk.c2d_ltr), .l1_enter_req(lnk.l1_enter_req),
        .wake_req(lnk.wake_req), .exit_req(lnk.exit_req), .link_state(lnk.link_state));
    ////////////////////////////////////////
    // Free-running clock.
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Bounded waits, sampled at the falling edge where outputs are settled.
    task automatic wait_dev(input logic [1:0] s);
        for (int i = 0; i < 40 && dev_state !== s; i++) @(negedge core_clk);
        chk("dev_state", 10'(dev_state), 10'(s));
    endtask : wait_dev
    task automatic wait_link(input logic [1:0] s);
        for (int i = 0; i < 40 && link_now !== s; i++) @(negedge core_clk);
        chk("link_now", 10'(link_now), 10'(s));
    endtask : wait_link
    task automatic wait_d2c(input logic [7:0] op);
        for (int i = 0; i < 20 && lnk.d2c_valid !== 1'b1; i++) @(negedge core_clk);
        chk("d2c_op", 10'(lnk.d2c_op), 10'(op));
        chk("d2c_tag", 10'(lnk.d2c_tag), 10'(PIPC_VDM_TAG));
    endtask : wait_d2c
    task automatic results();
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // Watchdog: the tests need well under a thousand cycles.
    initial
    begin
        #20000;
        n_mismatch++;
        results();
    end
    // Main sequence; inputs change only at the falling edge.
    initial
    begin
        {idle_wish, wake_wish, peer_needs_mem, mgmt_tx_valid} = '0;
        {cpu_halted, need_low_lat, send_rstprep, send_mgmt, send_idle_req} = '0;
        own_ltr = 10'h050;
        host_ltr = 10'h030;
        reset_n = 1'b0;
        repeat (8) @(negedge core_clk);
        reset_n = 1'b1;
        chk("link_now", 10'(link_now), 10'h000);
        peer_needs_mem = 1'b1;
        idle_wish = 1'b1;
        repeat (6) @(negedge core_clk);
        chk("dev_state", 10'(dev_state), 10'h000);
        peer_needs_mem = 1'b0;
        wait_d2c(PIPC_OP_REQ);
        chk("d2c_ltr", lnk.d2c_ltr, 10'h050);
        @(negedge core_clk);
        chk("req_seen", 10'(req_seen), 10'h001);
        wait_dev(2'h2);
        chk("granted_ltr", granted_ltr, 10'h030);
        chk("local_idle_ok", 10'(local_idle_ok), 10'h001);
        cpu_halted = 1'b1;
        wait_dev(2'h3);
        wait_link(2'h1);
        chk("proto_tx_ok", 10'(proto_tx_ok), 10'h000);
        idle_wish = 1'b0;
        wake_wish = 1'b1;
        wait_dev(2'h0);
        chk("link_now", 10'(link_now), 10'h000);
        chk("proto_tx_ok", 10'(proto_tx_ok), 10'h001);
        // Second entry with the device holding the tighter tolerance.
        wake_wish = 1'b0;
        own_ltr = 10'h020;
        idle_wish = 1'b1;
        wait_dev(2'h2);
        chk("granted_ltr", granted_ltr, 10'h020);
        wait_link(2'h1);
        need_low_lat = 1'b1;
        wait_dev(2'h0);
        chk("link_now", 10'(link_now), 10'h000);
        repeat (10) @(negedge core_clk);
        chk("dev_state", 10'(dev_state), 10'h000);
        chk("local_idle_ok", 10'(local_idle_ok), 10'h000);
        // Reset in mid-run, then a pending idle cancelled by reset-prepare.
        {need_low_lat, cpu_halted, idle_wish} = '0;
        reset_n = 1'b0;
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        idle_wish = 1'b1;
        wait_dev(2'h2);
        // The idle wish stays up, so only the reset-prepare can bring the device back.
        send_rstprep = 1'b1;
        @(negedge core_clk);
        send_rstprep = 1'b0;
        wait_dev(2'h0);
        idle_wish = 1'b0;
        mgmt_tx_valid = 1'b1;
        @(negedge core_clk);
        mgmt_tx_valid = 1'b0;
        wait_d2c(PIPC_OP_MGMT);
        // Management message in the other direction.
        send_mgmt = 1'b1;
        @(negedge core_clk);
        send_mgmt = 1'b0;
        @(negedge core_clk);
        chk("mgmt_rx_pulse", 10'(mgmt_rx_pulse), 10'h001);
        // Processor-side request answered with the tighter tolerance.
        send_idle_req = 1'b1;
        @(negedge core_clk);
        send_idle_req = 1'b0;
        wait_d2c(PIPC_OP_RSP);
        chk("d2c_ltr", lnk.d2c_ltr, 10'h020);
        results();
    end
endmodule : tb
`default_nettype wire
